//--- logic/scf_params.svh
`ifndef SCF_PARAMS_SVH
`define SCF_PARAMS_SVH
`define SCF_ADDR_STATUS 8'had
`define SCF_ADDR_IDENT 8'hae
`define SCF_ADDR_SELECT 8'hab
`define SCF_STATUS_RST 8'h80
`define SCF_IDENT_RST 8'h00
`define SCF_ENABLE_RST 8'h00
`define SCF_SELECT_RST 8'h00
`define SCF_RDATA_RST 8'h00
`define SCF_UNMAPPED_RD 8'h00
`define SCF_PAGE_BIT 0
`define SCF_BIT_TXBUF 7
`define SCF_BIT_CARD 6
`define SCF_BIT_CURR 5
`define SCF_BIT_VOLT 4
`define SCF_BIT_WAIT 3
`define SCF_BIT_SENT 2
`define SCF_BIT_RECV 1
`define SCF_BIT_PAR 0
`define SCF_IDENT_MASK 8'hbf
`define SCF_STATUS_SW_CLR 8'h0d
`define SCF_SELECT_MASK 8'h1f
`endif

//--- logic/scf_pkg.sv
package scf_pkg;
    typedef logic [7:0] scf_byte_t;
    typedef enum logic [1:0] {
        SCF_ACC_IDLE = 2'b00,
        SCF_ACC_READ = 2'b01,
        SCF_ACC_WRITE = 2'b10
    } scf_acc_t;
endpackage

//--- logic/scf_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for the analog monitor levels
module scf_sync
    import scf_pkg::*;
#(
    parameter int W = 3
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end
    assign q_o = q_ff;
endmodule

//--- logic/scf_flags.sv
`timescale 1ns/100ps
`include "scf_params.svh"
// Summary of operation
// - tx buffer moved to shift register sets status bit 7.
// - write to tx holding buffer clears status bit 7.
// - status bit 5 follows overcurrent; only hardware clears it.
// - character sent sets status bit 2.
// - character received sets status bit 1.
// - reading rx data buffer clears status bit 1.
// - status resets to 0x80.
// - status sits at ADh when page select is 0.
// - ident register at AEh when page select is 0, read only.
// - tx buffer move sets ident bit 7.
// - reading ident register clears all ident flags except one whose event coincides.
// - current leaving range sets ident bit 5.
// - voltage leaving selected range sets ident bit 4.
// - character sent sets ident bit 2.
// - character received sets ident bit 1.
// - ident bit 6 reserved, reads zero, writes ignored.
// - ident resets to all clear.
// - page 1 at AEh reaches enable register gating irq request.
// - page select is bit 0 of selection register ABh.
module scf_flags
    import scf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // special function register access
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_rd_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // uart events, same clock
    input wire logic tx_buf_load_i,
    input wire logic tx_buf_write_i,
    input wire logic char_sent_i,
    input wire logic char_received_i,
    input wire logic parity_error_i,
    input wire logic rx_buf_read_i,
    input wire logic wait_expired_i,
    // card monitor pins
    input wire logic card_detect_i,
    input wire logic overcurrent_i,
    input wire logic voltage_good_i,
    // outputs
    output logic irq_o,
    output logic register_page_select_o
);
    scf_byte_t status_ff, nxt_status;
    scf_byte_t ident_ff, nxt_ident;
    scf_byte_t enable_ff, nxt_enable;
    scf_byte_t select_ff, nxt_select;
    scf_byte_t rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq;
    logic curr_prev_ff, nxt_curr_prev;
    logic volt_prev_ff, nxt_volt_prev;
    logic [2:0] mon_s;
    logic card_s, curr_s, volt_s;
    scf_acc_t acc;

    // monitor levels are asynchronous to the core clock
    scf_sync #(.W(3)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .d_i({card_detect_i, overcurrent_i, voltage_good_i}),
        .q_o(mon_s)
    );
    assign card_s = mon_s[2];
    assign curr_s = mon_s[1];
    assign volt_s = mon_s[0];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a, input logic pg, input logic want);
        hit = (a == ref_a) && (pg == want);
    endfunction

    always_comb begin
        acc = SCF_ACC_IDLE;
        if (sfr_rd_i) begin
            acc = SCF_ACC_READ;
        end else if (sfr_wr_i) begin
            acc = SCF_ACC_WRITE;
        end
    end

    logic page;
    logic st_rd, st_wr, id_rd, en_rd, en_wr, sel_rd, sel_wr;
    assign page = select_ff[`SCF_PAGE_BIT];
    assign st_rd = (acc == SCF_ACC_READ) && hit(sfr_addr_i, `SCF_ADDR_STATUS, page, 1'b0);
    assign st_wr = (acc == SCF_ACC_WRITE) && hit(sfr_addr_i, `SCF_ADDR_STATUS, page, 1'b0);
    assign id_rd = (acc == SCF_ACC_READ) && hit(sfr_addr_i, `SCF_ADDR_IDENT, page, 1'b0);
    assign en_rd = (acc == SCF_ACC_READ) && hit(sfr_addr_i, `SCF_ADDR_IDENT, page, 1'b1);
    assign en_wr = (acc == SCF_ACC_WRITE) && hit(sfr_addr_i, `SCF_ADDR_IDENT, page, 1'b1);
    assign sel_rd = (acc == SCF_ACC_READ) && (sfr_addr_i == `SCF_ADDR_SELECT);
    assign sel_wr = (acc == SCF_ACC_WRITE) && (sfr_addr_i == `SCF_ADDR_SELECT);

    // status register: clears first, then sets so events win
    always_comb begin
        nxt_status = status_ff;
        if (tx_buf_write_i) begin
            nxt_status[`SCF_BIT_TXBUF] = 1'b0;
        end
        if (st_wr) begin
            // software may only clear the flags it owns, by writing zero
            nxt_status = nxt_status & (sfr_wdata_i | ~`SCF_STATUS_SW_CLR);
        end
        if (rx_buf_read_i) begin
            nxt_status[`SCF_BIT_RECV] = 1'b0;
        end
        if (tx_buf_load_i) begin
            nxt_status[`SCF_BIT_TXBUF] = 1'b1;
        end
        if (char_sent_i) begin
            nxt_status[`SCF_BIT_SENT] = 1'b1;
        end
        if (char_received_i) begin
            nxt_status[`SCF_BIT_RECV] = 1'b1;
        end
        if (parity_error_i && (char_sent_i || char_received_i)) begin
            nxt_status[`SCF_BIT_PAR] = 1'b1;
        end
        if (wait_expired_i) begin
            nxt_status[`SCF_BIT_WAIT] = 1'b1;
        end
        nxt_status[`SCF_BIT_CARD] = card_s;
        nxt_status[`SCF_BIT_CURR] = curr_s;
        nxt_status[`SCF_BIT_VOLT] = volt_s;
    end

    // identification flags: read clears, coinciding event keeps its flag
    always_comb begin
        nxt_ident = id_rd ? `SCF_IDENT_RST : ident_ff;
        nxt_curr_prev = curr_s;
        nxt_volt_prev = volt_s;
        if (tx_buf_load_i) begin
            nxt_ident[`SCF_BIT_TXBUF] = 1'b1;
        end
        if (curr_s && !curr_prev_ff) begin
            nxt_ident[`SCF_BIT_CURR] = 1'b1;
        end
        // voltage falling out of the selected window is the error edge
        if (!volt_s && volt_prev_ff) begin
            nxt_ident[`SCF_BIT_VOLT] = 1'b1;
        end
        if (wait_expired_i) begin
            nxt_ident[`SCF_BIT_WAIT] = 1'b1;
        end
        if (char_sent_i) begin
            nxt_ident[`SCF_BIT_SENT] = 1'b1;
        end
        if (char_received_i) begin
            nxt_ident[`SCF_BIT_RECV] = 1'b1;
        end
        if (parity_error_i && (char_sent_i || char_received_i)) begin
            nxt_ident[`SCF_BIT_PAR] = 1'b1;
        end
        nxt_ident = nxt_ident & `SCF_IDENT_MASK;
    end

    // enable, select, read data and interrupt request
    always_comb begin
        nxt_enable = en_wr ? (sfr_wdata_i & `SCF_IDENT_MASK) : enable_ff;
        nxt_select = sel_wr ? (sfr_wdata_i & `SCF_SELECT_MASK) : select_ff;
        nxt_rdata = rdata_ff;
        if (st_rd) begin
            nxt_rdata = status_ff;
        end else if (id_rd) begin
            nxt_rdata = ident_ff;
        end else if (en_rd) begin
            nxt_rdata = enable_ff;
        end else if (sel_rd) begin
            nxt_rdata = select_ff;
        end else if (acc == SCF_ACC_READ) begin
            nxt_rdata = `SCF_UNMAPPED_RD;
        end
        // request is built from next flags and next enables, so clearing an enable
        // drops the request in the same cycle instead of leaving one stale cycle
        nxt_irq = |(nxt_ident & nxt_enable);
    end

    // status group
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_ff <= `SCF_STATUS_RST;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ident group with its edge history
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ident_ff <= `SCF_IDENT_RST;
            curr_prev_ff <= 1'b0;
            volt_prev_ff <= 1'b0;
        end else begin
            ident_ff <= nxt_ident;
            curr_prev_ff <= nxt_curr_prev;
            volt_prev_ff <= nxt_volt_prev;
        end
    end

    // access group
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable_ff <= `SCF_ENABLE_RST;
            select_ff <= `SCF_SELECT_RST;
            rdata_ff <= `SCF_RDATA_RST;
            irq_ff <= 1'b0;
        end else begin
            enable_ff <= nxt_enable;
            select_ff <= nxt_select;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
        end
    end

    assign sfr_rdata_o = rdata_ff;
    assign irq_o = irq_ff;
    assign register_page_select_o = select_ff[`SCF_PAGE_BIT];

    // status flags; pin bits lag their pins by three cycles through the synchroniser
    tx_load_sets_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tx_buf_load_i |=> status_ff[`SCF_BIT_TXBUF] && ident_ff[`SCF_BIT_TXBUF])
        else $error("tx load flag missing");
    tx_write_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tx_buf_write_i && !tx_buf_load_i |=> !status_ff[`SCF_BIT_TXBUF])
        else $error("tx write not cleared");
    sent_sets_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        char_sent_i |=> status_ff[`SCF_BIT_SENT] && ident_ff[`SCF_BIT_SENT])
        else $error("sent flag missing");
    sent_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        status_ff[`SCF_BIT_SENT] && !(st_wr && !sfr_wdata_i[`SCF_BIT_SENT]) |=> status_ff[`SCF_BIT_SENT])
        else $error("sent flag lost without software clear");
    recv_sets_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        char_received_i |=> status_ff[`SCF_BIT_RECV] && ident_ff[`SCF_BIT_RECV])
        else $error("recv flag missing");
    rx_read_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        rx_buf_read_i && !char_received_i |=> !status_ff[`SCF_BIT_RECV])
        else $error("rx read not cleared");
    curr_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        overcurrent_i [*4] |-> status_ff[`SCF_BIT_CURR])
        else $error("overcurrent not shown");
    curr_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !overcurrent_i [*4] |-> !status_ff[`SCF_BIT_CURR])
        else $error("overcurrent not released");
    card_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        card_detect_i [*4] |-> status_ff[`SCF_BIT_CARD])
        else $error("card presence not shown");
    wait_sets_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        wait_expired_i |=> status_ff[`SCF_BIT_WAIT] && ident_ff[`SCF_BIT_WAIT])
        else $error("wait flag missing");
    par_with_char_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        parity_error_i && char_received_i |=> status_ff[`SCF_BIT_PAR] && ident_ff[`SCF_BIT_PAR])
        else $error("parity flag missing");

    // ident flags
    ident_read_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        id_rd && !tx_buf_load_i && !char_sent_i && !char_received_i && !wait_expired_i
        && !(curr_s && !curr_prev_ff) && !(!volt_s && volt_prev_ff) |=> ident_ff == `SCF_IDENT_RST)
        else $error("ident not cleared");
    ident_rsvd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !ident_ff[`SCF_BIT_CARD] && !enable_ff[`SCF_BIT_CARD])
        else $error("reserved bit set");
    curr_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        curr_s && !curr_prev_ff |=> ident_ff[`SCF_BIT_CURR])
        else $error("current error flag missing");
    volt_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !volt_s && volt_prev_ff |=> ident_ff[`SCF_BIT_VOLT])
        else $error("voltage error flag missing");
    event_wins_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        id_rd && char_sent_i |=> ident_ff[`SCF_BIT_SENT])
        else $error("event lost on read");

    // access and request
    ident_read_data_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        id_rd |=> sfr_rdata_o == $past(ident_ff))
        else $error("ident read data wrong");
    ident_ro_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        sfr_wr_i && !sfr_rd_i && (sfr_addr_i == `SCF_ADDR_IDENT) && !page |=> $stable(enable_ff))
        else $error("ident page write landed");
    irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        irq_o == |(ident_ff & enable_ff))
        else $error("irq gating wrong");
    irq_event_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        char_sent_i && enable_ff[`SCF_BIT_SENT] && !en_wr |=> irq_o)
        else $error("enabled event gave no request");

    // main scenarios
    rx_cycle_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        char_received_i ##[1:20] rx_buf_read_i);
    ident_clear_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        irq_o ##1 id_rd ##1 !irq_o);
    page_switch_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        en_wr ##[1:10] id_rd);
    tx_refill_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tx_buf_write_i ##[1:20] tx_buf_load_i);
    fault_seen_c: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (curr_s && !curr_prev_ff) ##[1:40] id_rd);
endmodule

//--- testbench/scf_card_model.sv
`timescale 1ns/100ps
// card side monitors: presence, supply current and supply voltage levels
// levels move on the falling edge so they stay unrelated to the sampling edge,
// which exercises the synchroniser rather than a lucky setup window
module scf_card_model
    import scf_pkg::*;
(
    // clock
    input wire logic ref_clk_i,
    // requested levels: 0 present, 1 overcurrent, 2 voltage good
    input wire logic [2:0] lvl_i,
    // monitor pins
    output logic card_detect_o,
    output logic overcurrent_o,
    output logic voltage_good_o
);
    initial begin
        card_detect_o = 1'b0;
        overcurrent_o = 1'b0;
        voltage_good_o = 1'b0;
    end
    always @(negedge ref_clk_i) begin
        card_detect_o <= lvl_i[0];
        overcurrent_o <= lvl_i[1];
        voltage_good_o <= lvl_i[2];
    end
endmodule

//--- testbench/scf_flags_tb_top.sv
`timescale 1ns/100ps
module scf_flags_tb_top;
    import scf_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [6:0] ev = 7'h00;
    logic [2:0] lvl = 3'h0;
    logic cd, oc, vg, irq, page;
    logic [7:0] rdata;
    int failures = 0;
    int checks = 0;

    scf_card_model scf_card_model_inst (.ref_clk_i(ref_clk), .lvl_i(lvl), .card_detect_o(cd),
        .overcurrent_o(oc), .voltage_good_o(vg));
    scf_flags scf_flags_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .sfr_addr_i(addr), .sfr_rd_i(rd_s),
        .sfr_wr_i(wr_s), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .tx_buf_load_i(ev[0]),
        .tx_buf_write_i(ev[1]), .char_sent_i(ev[2]), .char_received_i(ev[3]), .parity_error_i(ev[4]),
        .rx_buf_read_i(ev[5]), .wait_expired_i(ev[6]), .card_detect_i(cd), .overcurrent_i(oc),
        .voltage_good_i(vg), .irq_o(irq), .register_page_select_o(page));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    task finish_test;
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    // read with optional same-cycle events, so clear-versus-set races can be staged
    task rd(input logic [7:0] a, input logic [6:0] e, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        ev <= e;
        @(posedge ref_clk);
        rd_s <= 1'b0;
        ev <= 7'h00;
        #1 chk(rdata, exp);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk);
        wr_s <= 1'b0;
    endtask

    task pulse(input logic [6:0] e);
        @(posedge ref_clk);
        ev <= e;
        @(posedge ref_clk);
        ev <= 7'h00;
    endtask

    // pins pass a two-stage synchroniser, allow margin over its three cycles
    task pins(input logic [2:0] l);
        @(posedge ref_clk);
        lvl <= l;
        repeat (5) @(posedge ref_clk);
    endtask

    initial begin
        #100000;
        failures++;
        finish_test;
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(8'had, 7'h00, 8'h80);
        rd(8'hae, 7'h00, 8'h00);
        rd(8'h10, 7'h00, 8'h00);
        pulse(7'h02);
        rd(8'had, 7'h00, 8'h00);
        pulse(7'h01);
        rd(8'had, 7'h00, 8'h80);
        rd(8'hae, 7'h00, 8'h80);
        rd(8'hae, 7'h00, 8'h00);
        pulse(7'h04);
        rd(8'had, 7'h00, 8'h84);
        rd(8'hae, 7'h00, 8'h04);
        wr(8'had, 8'h00);
        rd(8'had, 7'h00, 8'h80);
        pulse(7'h18);
        rd(8'had, 7'h00, 8'h83);
        rd(8'hae, 7'h00, 8'h03);
        pulse(7'h20);
        rd(8'had, 7'h00, 8'h81);
        wr(8'had, 8'h00);
        pulse(7'h40);
        rd(8'had, 7'h00, 8'h88);
        rd(8'hae, 7'h00, 8'h08);
        wr(8'had, 8'h00);
        // software leaves the reserved bit alone; the whole register ignores writes
        wr(8'hae, 8'hbf);
        rd(8'hae, 7'h00, 8'h00);
        rd(8'hae, 7'h08, 8'h00);
        rd(8'hae, 7'h00, 8'h02);
        pulse(7'h20);
        pins(3'b001);
        rd(8'had, 7'h00, 8'hc0);
        pins(3'b011);
        rd(8'had, 7'h00, 8'he0);
        rd(8'hae, 7'h00, 8'h20);
        wr(8'had, 8'h00);
        rd(8'had, 7'h00, 8'he0);
        pins(3'b001);
        rd(8'had, 7'h00, 8'hc0);
        pins(3'b101);
        rd(8'had, 7'h00, 8'hd0);
        pins(3'b001);
        rd(8'hae, 7'h00, 8'h10);
        wr(8'hab, 8'h01);
        @(posedge ref_clk);
        #1 chk_bit(page, 1'b1);
        wr(8'hae, 8'hff);
        rd(8'hae, 7'h00, 8'hbf);
        pulse(7'h04);
        repeat (2) @(posedge ref_clk);
        #1 chk_bit(irq, 1'b1);
        wr(8'hae, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1 chk_bit(irq, 1'b0);
        wr(8'hab, 8'h00);
        rd(8'hae, 7'h00, 8'h04);
        finish_test;
    end
endmodule
